// *** sfh_sample_fifo_port.sv ***
// host register port for the transmit and receive sample fifos
//
// Overview of operation
// [RQ1] every fifo entry is 16 bits: control high byte, data low byte
// [RQ2] word write pushes whole value and keeps its high byte as control
// [RQ3] data byte write pushes held control byte with the written byte
// [RQ4] control byte write only updates the held control byte
// [RQ5] receive control byte read shows oldest entry, removes nothing
// [RQ6] receive data byte read returns data, removes entry, refreshes views
// [RQ7] receive word read returns whole oldest entry and removes it
// [RQ8] fill levels readable, fifo control writable, thresholds flagged
// [RQ9] mode selects transmit channels, receive format, or both at once
// [RQ10] sync bit set on first receive block entry, clear on others
// [RQ11] first entry bits 10..8 give the receive sample type
// [RQ12] second entry control byte holds the receive sample number
// [RQ13] pair blocks hold four bytes, single blocks hold two
// [RQ14] phase and magnitude blocks hold phase bytes then magnitude bytes
// [RQ15] phase and magnitude samples are derived from the sampled pair
// [RQ16] transmit takes single samples for either dac or dual pairs
// [RQ17] host may read only data bytes once block alignment is known
// [RQ18] transmit treats sync one-to-zero change as block start
// [RQ19] transmit done flag sets after end block follows last sample
// [RQ20] empty reads remove nothing, full writes keep stored entries
`timescale 1ns/1ps
module sfh_sample_fifo_port import sfh_pkg::*; #(
    parameter int DEPTH = 64,
    parameter int LW    = 7
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata_r,
    output logic             reg_rvalid_r,
    // receive sample source
    input  wire logic        rx_tick,
    input  wire logic [15:0] adc1_in,
    input  wire logic [15:0] adc2_in,
    // transmit sample sink
    input  wire logic        tx_tick,
    output logic      [15:0] dac1_r,
    output logic      [15:0] dac2_r,
    output logic             dac_valid_r
);
    // ==========================================================
    // register decode
    logic wr_tx_word;
    logic wr_tx_data;
    logic wr_tx_ctrl;
    logic wr_fctl;
    logic wr_mode;
    logic rd_rx_word;
    logic rd_rx_data;
    logic rd_status;

    assign wr_tx_word = reg_wr && reg_addr == ADDR_TX_WORD;
    assign wr_tx_data = reg_wr && reg_addr == ADDR_TX_DATA;
    assign wr_tx_ctrl = reg_wr && reg_addr == ADDR_TX_CTRL;
    assign wr_fctl    = reg_wr && reg_addr == ADDR_FIFO_CTL;
    assign wr_mode    = reg_wr && reg_addr == ADDR_MODE;
    assign rd_rx_word = reg_rd && reg_addr == ADDR_RX_WORD;
    assign rd_rx_data = reg_rd && reg_addr == ADDR_RX_DATA;
    assign rd_status  = reg_rd && reg_addr == ADDR_STATUS;

    // ==========================================================
    // control registers
    logic [15:0] mode_r;
    logic [15:0] fctl_r;
    logic [7:0]  ctrl_byte_r;
    logic [7:0]  ctrl_byte_nxt;
    logic        tx_flush;
    logic        rx_flush;
    logic [1:0]  tx_sel;
    logic [2:0]  rx_type;
    logic        rx_en;

    assign tx_sel   = mode_r[MODE_TX_LSB +: 2];                       // [RQ9]
    assign rx_type  = mode_r[MODE_RXT_LSB +: 3];                      // [RQ9]
    assign rx_en    = mode_r[MODE_RX_EN];                             // [RQ9]
    assign tx_flush = wr_fctl && reg_wdata[FCTL_TX_FLUSH];            // [RQ8]
    assign rx_flush = wr_fctl && reg_wdata[FCTL_RX_FLUSH];            // [RQ8]

    assign ctrl_byte_nxt = wr_tx_word ? reg_wdata[15:8] :             // [RQ2]
                           wr_tx_ctrl ? reg_wdata[7:0] :              // [RQ4]
                           ctrl_byte_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            mode_r      <= MODE_RST;
            fctl_r      <= FCTL_RST;
            ctrl_byte_r <= CTRL_RST;
        end else begin
            mode_r      <= wr_mode ? reg_wdata : mode_r;
            fctl_r      <= wr_fctl ? reg_wdata : fctl_r;
            ctrl_byte_r <= ctrl_byte_nxt;
        end
    end

    // ==========================================================
    // transmit fifo
    logic [15:0]   tx_din;
    logic          tx_push;
    logic          tx_pop;
    logic [15:0]   tx_head;
    logic [LW-1:0] tx_count;
    logic          tx_empty;

    assign tx_push = wr_tx_word || wr_tx_data;                        // [RQ2] [RQ3]
    assign tx_din  = wr_tx_word ? reg_wdata :                         // [RQ2]
                     {ctrl_byte_r, reg_wdata[7:0]};                   // [RQ3]

    // a push into a full fifo is dropped inside the fifo
    sfh_fifo #(
        .W     (ENTRY_W),
        .DEPTH (DEPTH),
        .LW    (LW)
    ) u_tx_fifo (
        .clock   (clock),
        .rst     (rst),
        .flush   (tx_flush),
        .push    (tx_push),
        .din     (tx_din),
        .pop     (tx_pop),
        .dout_r  (tx_head),
        .count_r (tx_count),
        .empty   (tx_empty),
        .full    ()
    );                                                                // [RQ1] [RQ20]

    // ==========================================================
    // transmit block assembly
    sfh_tx_state_type tx_state_r;
    logic [1:0]  pos_r;
    logic [1:0]  pos_eff;
    logic [1:0]  lane;
    logic [1:0]  last_pos;
    logic        prev_sync_r;
    logic        head_sync;
    logic        head_end;
    logic [31:0] smp_r;
    logic        tx_done_r;
    logic        tx_done_set;

    assign head_sync = tx_head[SYNC_BIT];
    assign head_end  = head_sync && tx_head[TYPE_LSB +: 3] == TYPE_TXEND;
    assign tx_pop    = tx_state_r == TX_FILL && !tx_empty && tx_sel != 2'h0;
    // a one-to-zero change means the previous entry opened the block
    assign pos_eff   = (prev_sync_r && !head_sync) ? 2'd1 : pos_r;    // [RQ18]
    assign last_pos  = (tx_sel == TXSEL_BOTH) ? 2'd3 : 2'd1;          // [RQ16]
    assign lane      = (tx_sel == TXSEL_DAC2) ? pos_eff + 2'd2 : pos_eff;
    // pops only happen with no sample pending, so the last one is out
    assign tx_done_set = tx_pop && head_end;                          // [RQ19]

    always_ff @(posedge clock) begin
        if (rst || tx_flush) begin
            tx_state_r  <= TX_FILL;
            pos_r       <= '0;
            prev_sync_r <= 1'b0;
            smp_r       <= '0;
        end else begin
            unique case (tx_state_r)
                TX_FILL: begin
                    if (tx_pop) begin
                        prev_sync_r <= head_sync;
                        if (head_end) begin
                            pos_r <= '0;
                        end else begin
                            smp_r[(3 - lane) * 8 +: 8] <= tx_head[7:0]; // [RQ16]
                            pos_r <= (pos_eff == last_pos) ? 2'd0 : pos_eff + 2'd1; // [RQ18]
                            if (pos_eff == last_pos) begin
                                tx_state_r <= TX_HOLD;
                            end
                        end
                    end
                end
                TX_HOLD: begin
                    if (tx_tick) begin
                        tx_state_r <= TX_FILL;
                    end
                end
            endcase
        end
    end

    // unselected channel keeps its previous value
    always_ff @(posedge clock) begin
        if (rst) begin
            dac1_r      <= '0;
            dac2_r      <= '0;
            dac_valid_r <= 1'b0;
        end else begin
            dac_valid_r <= tx_state_r == TX_HOLD && tx_tick;
            if (tx_state_r == TX_HOLD && tx_tick) begin
                if (tx_sel != TXSEL_DAC2) begin
                    dac1_r <= smp_r[31:16];                           // [RQ16]
                end
                if (tx_sel != TXSEL_DAC1) begin
                    dac2_r <= smp_r[15:0];                            // [RQ16]
                end
            end
        end
    end

    // ==========================================================
    // receive path
    logic [15:0]   rx_entry;
    logic          rx_entry_valid;
    logic [15:0]   rx_head;
    logic [LW-1:0] rx_count;
    logic          rx_empty;
    logic          rx_full;
    logic          rx_pop;
    logic          rx_ovf_r;
    logic          rx_ovf_set;

    sfh_rx_packer u_rx_packer (
        .clock         (clock),
        .rst           (rst),
        .enable        (rx_en),
        .tick          (rx_tick),
        .stype         (rx_type),
        .adc1          (adc1_in),
        .adc2          (adc2_in),
        .entry_r       (rx_entry),
        .entry_valid_r (rx_entry_valid)
    );                                                                // [RQ15]

    // only word and data byte reads consume, and never from empty
    assign rx_pop     = (rd_rx_word || rd_rx_data) && !rx_empty;      // [RQ6] [RQ7] [RQ20]
    assign rx_ovf_set = rx_entry_valid && rx_full;

    sfh_fifo #(
        .W     (ENTRY_W),
        .DEPTH (DEPTH),
        .LW    (LW)
    ) u_rx_fifo (
        .clock   (clock),
        .rst     (rst),
        .flush   (rx_flush),
        .push    (rx_entry_valid),
        .din     (rx_entry),
        .pop     (rx_pop),
        .dout_r  (rx_head),
        .count_r (rx_count),
        .empty   (rx_empty),
        .full    (rx_full)
    );                                                                // [RQ1]

    // ==========================================================
    // status flags: a set in the clearing read's cycle survives
    logic tx_low;
    logic rx_high;

    assign tx_low  = 16'(tx_count) <= 16'(fctl_r[FCTL_TXT_LSB +: 6]); // [RQ8]
    assign rx_high = 16'(rx_count) >= 16'(fctl_r[FCTL_RXT_LSB +: 8]); // [RQ8]

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_done_r <= 1'b0;
            rx_ovf_r  <= 1'b0;
        end else begin
            tx_done_r <= tx_done_set || (tx_done_r && !rd_status);    // [RQ19]
            rx_ovf_r  <= rx_ovf_set || (rx_ovf_r && !rd_status);
        end
    end

    // ==========================================================
    // read data; an empty receive fifo reads as zero
    logic [15:0] rx_view;
    logic [15:0] status_val;
    logic [15:0] rd_mux;

    assign rx_view    = rx_empty ? 16'h0000 : rx_head;
    assign status_val = {12'h000, rx_ovf_r, rx_high, tx_low, tx_done_r};
    assign rd_mux =
        (reg_addr == ADDR_RX_WORD)  ? rx_view :                       // [RQ7]
        (reg_addr == ADDR_RX_DATA)  ? {8'h00, rx_view[7:0]} :         // [RQ6]
        (reg_addr == ADDR_RX_CTRL)  ? {8'h00, rx_view[15:8]} :        // [RQ5]
        (reg_addr == ADDR_TX_LEVEL) ? 16'(tx_count) :                 // [RQ8]
        (reg_addr == ADDR_RX_LEVEL) ? 16'(rx_count) :                 // [RQ8]
        (reg_addr == ADDR_STATUS)   ? status_val :
        16'h0000;

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata_r  <= '0;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            reg_rdata_r  <= reg_rd ? rd_mux : reg_rdata_r;
        end
    end
endmodule : sfh_sample_fifo_port

// *** sfh_pkg.sv ***
// shared constants and types for the sample fifo host port
package sfh_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] ADDR_TX_WORD  = 8'h48;
    localparam logic [7:0] ADDR_TX_DATA  = 8'h49;
    localparam logic [7:0] ADDR_TX_CTRL  = 8'h4a;
    localparam logic [7:0] ADDR_TX_LEVEL = 8'h4b;
    localparam logic [7:0] ADDR_RX_WORD  = 8'h4c;
    localparam logic [7:0] ADDR_RX_DATA  = 8'h4d;
    localparam logic [7:0] ADDR_RX_CTRL  = 8'h4e;
    localparam logic [7:0] ADDR_RX_LEVEL = 8'h4f;
    localparam logic [7:0] ADDR_FIFO_CTL = 8'h50;
    localparam logic [7:0] ADDR_MODE     = 8'h6b;
    localparam logic [7:0] ADDR_STATUS   = 8'h7e;
    // ==========================================================
    // entry fields and block type codes
    localparam int         ENTRY_W    = 16;
    localparam int         SYNC_BIT   = 15;
    localparam int         TYPE_LSB   = 8;
    localparam logic [2:0] TYPE_PAIR  = 3'h0;
    localparam logic [2:0] TYPE_ADC1  = 3'h1;
    localparam logic [2:0] TYPE_ADC2  = 3'h2;
    localparam logic [2:0] TYPE_TXEND = 3'h3;
    localparam logic [2:0] TYPE_PHMAG = 3'h4;
    // ==========================================================
    // mode, fifo control and status fields
    localparam int         MODE_TX_LSB   = 0;
    localparam int         MODE_RXT_LSB  = 2;
    localparam int         MODE_RX_EN    = 5;
    localparam logic [1:0] TXSEL_DAC1    = 2'h1;
    localparam logic [1:0] TXSEL_DAC2    = 2'h2;
    localparam logic [1:0] TXSEL_BOTH    = 2'h3;
    localparam int         FCTL_TX_FLUSH = 0;
    localparam int         FCTL_RX_FLUSH = 1;
    localparam int         FCTL_TXT_LSB  = 2;
    localparam int         FCTL_RXT_LSB  = 8;
    localparam int         ST_TX_DONE    = 0;
    localparam int         ST_TX_LOW     = 1;
    localparam int         ST_RX_HIGH    = 2;
    localparam int         ST_RX_OVF     = 3;
    // ==========================================================
    // reset values
    localparam logic [15:0] MODE_RST  = 16'h0000;
    localparam logic [15:0] FCTL_RST  = 16'h0000;
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    // ==========================================================
    // transmit assembly states
    typedef enum logic [1:0] {
        TX_FILL = 2'b01,
        TX_HOLD = 2'b10
    } sfh_tx_state_type;
endpackage : sfh_pkg

// *** sfh_fifo.sv ***
// synchronous fifo whose head entry is held in a register
`timescale 1ns/1ps
module sfh_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 64,
    parameter int LW    = 7
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          flush,
    // write side
    input  wire logic          push,
    input  wire logic [W-1:0]  din,
    // read side
    input  wire logic          pop,
    output logic      [W-1:0]  dout_r,
    output logic      [LW-1:0] count_r,
    output logic               empty,
    output logic               full
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW-1:0] rp_nxt;
    logic          do_push;
    logic          do_pop;

    // ==========================================================
    // full push and empty pop are dropped, stored data untouched
    assign empty   = (count_r == '0);
    assign full    = (count_r == LW'(DEPTH));
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign rp_nxt  = do_pop ? rp_r + 1'b1 : rp_r;

    always_ff @(posedge clock) begin
        if (do_push) begin
            mem[wp_r] <= din;
        end
    end

    // head register: bypass when the push lands on the new head
    always_ff @(posedge clock) begin
        if (rst || flush) begin
            wp_r    <= '0;
            rp_r    <= '0;
            count_r <= '0;
            dout_r  <= '0;
        end else begin
            wp_r    <= do_push ? wp_r + 1'b1 : wp_r;
            rp_r    <= rp_nxt;
            count_r <= count_r + LW'(do_push) - LW'(do_pop);
            dout_r  <= (do_push && wp_r == rp_nxt) ? din : mem[rp_nxt];
        end
    end
endmodule : sfh_fifo

// *** sfh_rx_packer.sv ***
// builds receive sample blocks from adc samples, one entry a clock
`timescale 1ns/1ps
module sfh_rx_packer import sfh_pkg::*; (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // sample source
    input  wire logic        enable,
    input  wire logic        tick,
    input  wire logic [2:0]  stype,
    input  wire logic [15:0] adc1,
    input  wire logic [15:0] adc2,
    // entry output
    output logic      [15:0] entry_r,
    output logic             entry_valid_r
);
    logic [31:0] buf_r;
    logic [2:0]  type_r;
    logic [6:0]  num_r;
    logic [6:0]  stamp_r;
    logic [1:0]  idx_r;
    logic [1:0]  last_r;
    logic        busy_r;
    logic [15:0] a1;
    logic [15:0] a2;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [16:0] mag_sum;
    logic [15:0] mag;
    logic [15:0] phase;
    logic [31:0] pick;
    logic [7:0]  ctrl;
    logic        take;

    // ==========================================================
    // coarse polar conversion; phase carries only the octant
    assign a1      = adc1[15] ? 16'(-adc1) : adc1;
    assign a2      = adc2[15] ? 16'(-adc2) : adc2;
    assign hi      = (a1 > a2) ? a1 : a2;
    assign lo      = (a1 > a2) ? a2 : a1;
    assign mag_sum = {1'b0, hi} + {2'b00, lo[15:1]};
    assign mag     = mag_sum[16] ? 16'hffff : mag_sum[15:0];          // [RQ15]
    assign phase   = {adc2[15], adc1[15], a2 > a1, 13'h0000};          // [RQ15]

    // block layout: first sample high, low, then second high, low
    assign pick = (stype == TYPE_PHMAG) ? {phase, mag} :               // [RQ14]
                  (stype == TYPE_ADC2)  ? {adc2, 16'h0000} :           // [RQ13]
                  {adc1, adc2};                                        // [RQ13]
    assign take = enable && tick && !busy_r;

    // sync only on first entry, type below it, stamp on the second
    assign ctrl = (idx_r == 2'd0) ? {1'b1, 4'h0, type_r} :             // [RQ10] [RQ11]
                  (idx_r == 2'd1) ? {1'b0, stamp_r} :                  // [RQ12]
                  8'h00;                                               // [RQ10]

    // ==========================================================
    // a tick during emission is lost but still advances the stamp
    always_ff @(posedge clock) begin
        if (rst) begin
            num_r <= '0;
        end else if (enable && tick) begin
            num_r <= num_r + 7'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            busy_r        <= 1'b0;
            idx_r         <= '0;
            last_r        <= '0;
            buf_r         <= '0;
            type_r        <= '0;
            stamp_r       <= '0;
            entry_r       <= '0;
            entry_valid_r <= 1'b0;
        end else begin
            entry_valid_r <= busy_r;
            if (busy_r) begin
                entry_r <= {ctrl, buf_r[(3 - idx_r) * 8 +: 8]};
                idx_r   <= idx_r + 2'd1;
                busy_r  <= (idx_r != last_r);
            end
            if (take) begin
                busy_r  <= 1'b1;
                idx_r   <= '0;
                buf_r   <= pick;
                type_r  <= stype;
                stamp_r <= num_r;
                last_r  <= (stype == TYPE_ADC1 || stype == TYPE_ADC2) ? 2'd1 : 2'd3;
            end
        end
    end
endmodule : sfh_rx_packer

// *** sfh_port_monitor.sv ***
// checker for the sample fifo host port
`timescale 1ns/1ps
module sfh_port_monitor import sfh_pkg::*; (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata_r,
    input wire logic        reg_rvalid_r,
    // transmit sink
    input wire logic        tx_tick,
    input wire logic [15:0] dac1_r,
    input wire logic [15:0] dac2_r,
    input wire logic        dac_valid_r
);
    // ========
    // read handshake
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_answer;
        reg_rvalid_r;
    endsequence
    AST_RVALID_AFTER_READ: assert property (
        reg_rd |=> s_answer) else $error("read not answered on the next cycle");
    AST_NO_STRAY_RVALID: assert property (
        !reg_rd |=> !reg_rvalid_r) else $error("read valid without a read");
    AST_RDATA_HOLDS: assert property (
        !reg_rvalid_r |-> $stable(reg_rdata_r)) else $error("read data moved without read");
    // ========
    // byte views and write-only places
    AST_TXCTRL_READS_ZERO: assert property (
        s_rd(ADDR_TX_CTRL) |=> reg_rdata_r == 16'h0) else $error("write-only read not zero");
    AST_MODE_READS_ZERO: assert property (
        s_rd(ADDR_MODE) |=> reg_rdata_r == 16'h0) else $error("mode read not zero");
    AST_RXCTRL_BYTE: assert property (
        s_rd(ADDR_RX_CTRL) |=> reg_rdata_r[15:8] == 8'h0) else $error("control view too wide");
    AST_RXDATA_BYTE: assert property (
        s_rd(ADDR_RX_DATA) |=> reg_rdata_r[15:8] == 8'h0) else $error("data view too wide");
    // ========
    // dac outputs
    AST_DAC_ON_TICK: assert property (
        dac_valid_r |-> $past(tx_tick)) else $error("dac update without a slot");
    AST_DAC_HOLDS: assert property (
        !dac_valid_r |-> $stable({dac1_r, dac2_r})) else $error("dac moved without update");
endmodule : sfh_port_monitor

bind sfh_sample_fifo_port sfh_port_monitor mon_u (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
    .reg_rvalid_r(reg_rvalid_r), .tx_tick(tx_tick), .dac1_r(dac1_r), .dac2_r(dac2_r),
    .dac_valid_r(dac_valid_r));

// *** sfh_host_model.sv ***
// host controller model driving the register port
`timescale 1ns/1ps
module sfh_host_model (
    // clock
    input  wire logic        clock,
    // register port
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata_r,
    input  wire logic        reg_rvalid_r
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // released lines show the inverse so no stale value passes for a real one
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    // data-only reads are legal once block alignment is known
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clock);
        d = (reg_rvalid_r === 1'b1) ? reg_rdata_r : 16'hxxxx;
    endtask : rd
endmodule : sfh_host_model

// *** sfh_sample_fifo_port_bench.sv ***
// self-checking bench for the sample fifo host port
`timescale 1ns/1ps
module sfh_sample_fifo_port_bench;
    import sfh_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic [15:0] e;} sfh_row_type;
    logic        clock, rst, reg_wr, reg_rd, reg_rvalid_r, rx_tick, tx_tick, dac_valid_r;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata_r, adc1_in, adc2_in, dac1_r, dac2_r, v, s1;
    int          mismatches = 0;
    int          compares = 0;
    int          cycles = 0;
    logic [7:0]  pb [4] = '{8'ha1, 8'hb2, 8'hc3, 8'hd4};
    sfh_row_type rows [12] = '{
        '{1'b1, ADDR_TX_WORD, 16'h8112, 16'h0}, '{1'b0, ADDR_TX_LEVEL, 16'h0, 16'h0001},
        '{1'b1, ADDR_TX_CTRL, 16'h0055, 16'h0}, '{1'b0, ADDR_TX_LEVEL, 16'h0, 16'h0001},
        '{1'b1, ADDR_TX_DATA, 16'h0033, 16'h0}, '{1'b0, ADDR_TX_LEVEL, 16'h0, 16'h0002},
        '{1'b0, ADDR_TX_WORD, 16'h0, 16'h0}, '{1'b0, 8'h00, 16'h0, 16'h0},
        '{1'b1, ADDR_FIFO_CTL, 16'h0001, 16'h0}, '{1'b0, ADDR_TX_LEVEL, 16'h0, 16'h0},
        '{1'b0, ADDR_TX_CTRL, 16'h0, 16'h0}, '{1'b0, ADDR_MODE, 16'h0, 16'h0}};
    // ========
    // design and host
    sfh_sample_fifo_port dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r), .rx_tick(rx_tick), .adc1_in(adc1_in), .adc2_in(adc2_in),
        .tx_tick(tx_tick), .dac1_r(dac1_r), .dac2_r(dac2_r), .dac_valid_r(dac_valid_r));
    sfh_host_model host_u (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ========
    // helpers
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rx_pulse(input logic [15:0] a, input logic [15:0] b);
        @(posedge clock);
        rx_tick <= 1'b1;
        adc1_in <= a;
        adc2_in <= b;
        @(posedge clock);
        rx_tick <= 1'b0;
        adc1_in <= ~a;
        adc2_in <= ~b;
        repeat (6) @(posedge clock);
    endtask : rx_pulse
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    // limit well above the roughly 150 cycles the sequence needs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            summarize();
        end
    end
    // ========
    // main sequence
    initial begin
        rst = 1'b1;
        rx_tick = 1'b0;
        tx_tick = 1'b0;
        adc1_in = 16'h0000;
        adc2_in = 16'h0000;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) host_u.wr(rows[i].a, rows[i].d);
            else begin
                host_u.rd(rows[i].a, v);
                chk("table read", rows[i].e, v);
            end
        end
        // held control byte feeds later byte writes
        host_u.wr(ADDR_TX_WORD, 16'h81aa);
        host_u.wr(ADDR_TX_CTRL, 16'h0000);
        host_u.wr(ADDR_TX_DATA, 16'h00bb);
        host_u.wr(ADDR_MODE, {14'h0, TXSEL_DAC1});
        repeat (4) @(posedge clock);
        tx_tick <= 1'b1;
        @(posedge clock);
        tx_tick <= 1'b0;
        #1;
        for (int i = 0; i < 4 && dac_valid_r !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk("dac1", 16'haabb, dac1_r);
        chk("dac2", 16'h0000, dac2_r);
        host_u.wr(ADDR_TX_WORD, 16'h8300);
        repeat (4) @(posedge clock);
        host_u.rd(ADDR_STATUS, v);
        chk("tx done", 16'h0001, v & 16'h0001);
        host_u.rd(ADDR_STATUS, v);
        chk("tx done cleared", 16'h0000, v & 16'h0001);
        // pair block read through data bytes only
        host_u.wr(ADDR_MODE, 16'h0020);
        rx_pulse(16'ha1b2, 16'hc3d4);
        host_u.rd(ADDR_RX_LEVEL, v);
        chk("pair level", 16'h0004, v);
        host_u.rd(ADDR_RX_CTRL, v);
        chk("pair head", 16'h0080, v);
        for (int i = 0; i < 4; i++) begin
            if (i == 1) host_u.rd(ADDR_RX_CTRL, s1);
            host_u.rd(ADDR_RX_DATA, v);
            chk("pair byte", {8'h00, pb[i]}, v);
        end
        // single channel block, then phase and magnitude head, through word reads
        host_u.wr(ADDR_MODE, 16'h0024);
        rx_pulse(16'h1234, 16'h5678);
        host_u.rd(ADDR_RX_CTRL, v);
        host_u.rd(ADDR_RX_CTRL, v);
        chk("adc1 head", 16'h0081, v);
        host_u.rd(ADDR_RX_WORD, v);
        chk("adc1 word", 16'h8112, v);
        host_u.rd(ADDR_RX_CTRL, v);
        chk("stamp", {9'h0, 7'(s1[6:0] + 7'h1)}, v);
        host_u.rd(ADDR_RX_WORD, v);
        chk("adc1 low", 16'h0034, v & 16'h80ff);
        host_u.rd(ADDR_RX_WORD, v);
        chk("empty read", 16'h0000, v);
        host_u.rd(ADDR_RX_LEVEL, v);
        chk("empty level", 16'h0000, v);
        host_u.wr(ADDR_MODE, 16'h0030);
        rx_pulse(16'h0300, 16'h0400);
        host_u.rd(ADDR_RX_WORD, v);
        chk("phmag head", 16'h8420, v);
        // reset in mid-run empties the transmit fifo
        host_u.wr(ADDR_TX_WORD, 16'h0011);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        host_u.rd(ADDR_TX_LEVEL, v);
        chk("level after reset", 16'h0000, v);
        summarize();
    end
endmodule : sfh_sample_fifo_port_bench
